// ---- verilog/sqa_pkg.sv ----
// Constants, register map and decoding helpers for the query and ack block
package sqa_pkg;

	// ==========================================================
	// Register byte offsets (one aligned 32-bit word each)
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RESP0  = 8'h08;
	localparam logic [7:0] OFS_RESP1  = 8'h0C;
	localparam logic [7:0] OFS_RESP2  = 8'h10;
	localparam logic [7:0] OFS_RESP3  = 8'h14;
	localparam logic [7:0] OFS_RINFO  = 8'h18;
	localparam logic [7:0] OFS_CFG232 = 8'h1C;
	localparam logic [7:0] OFS_CFG485 = 8'h20;
	localparam logic [7:0] OFS_RAMFLT = 8'h24;

	// ==========================================================
	// Command word fields
	localparam int CMD_OP_LSB    = 0;
	localparam int CMD_SRC_LSB   = 4;
	localparam int CMD_HASP_BIT  = 6;
	localparam int CMD_ERR_BIT   = 7;
	localparam int CMD_PARAM_LSB = 8;

	// Status, response info, config and fault word fields
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_RV_BIT     = 1;
	localparam int ST_ACK_LSB    = 2;
	localparam int RI_ISACK_BIT  = 3;
	localparam int RI_CHAR_LSB   = 8;
	localparam int CFG_BAUD_LSB  = 0;
	localparam int CFG_PAR_LSB   = 4;
	localparam int CFG_STOP_LSB  = 8;
	localparam int CFG_DBITS_LSB = 12;
	localparam int FLT_ADDR_LSB  = 16;

	// ==========================================================
	// Command opcodes
	localparam logic [3:0] OP_SERIAL_SETTINGS_QUERY = 4'h1;
	localparam logic [3:0] OP_SWITCH_AND_RAM_QUERY  = 4'h2;
	localparam logic [3:0] OP_ACK_OUTPUT_SELECT     = 4'h3;
	localparam logic [3:0] OP_SETUP_GENERIC         = 4'h4;

	// Host interface codes, also the port identifier field
	localparam logic [1:0] IF_BUS   = 2'h0;
	localparam logic [1:0] IF_RS232 = 2'h1;
	localparam logic [1:0] IF_RS485 = 2'h2;

	// Acknowledgment characters and power-on enables (bus off, serial on)
	localparam logic [7:0] ACK_OK    = 8'h30;
	localparam logic [7:0] ACK_ERR   = 8'h3F;
	localparam logic [2:0] ACK_RESET = 3'h6;

	// Serial settings limits and factory values
	localparam logic [2:0] BAUD_MAX   = 3'h6;
	localparam logic [1:0] PAR_MAX    = 2'h2;
	localparam logic [1:0] STOP_MIN   = 2'h1;
	localparam logic [1:0] STOP_MAX   = 2'h2;
	localparam logic [2:0] BAUD_RESET = 3'h5;
	localparam logic [1:0] PAR_RESET  = 2'h2;
	localparam logic [1:0] STOP_RESET = 2'h1;
	localparam logic [3:0] DATA_BITS  = 4'h8;

	// ==========================================================
	// Connection board RAM and its self test
	localparam int         RAM_DEPTH    = 1024;
	localparam int         RAM_AW       = 10;
	localparam logic [7:0] RAM_PATTERN  = 8'h55;
	localparam logic [7:0] RAM_FLIP     = 8'h01;
	localparam int         RAM_TEST_CYC = 4 * RAM_DEPTH + 4;

	// Baud rate code to rate in baud
	function automatic logic [15:0] baud_rate(input logic [2:0] code);
		case (code)
			3'h0:    baud_rate = 16'h012C;
			3'h1:    baud_rate = 16'h0258;
			3'h2:    baud_rate = 16'h04B0;
			3'h3:    baud_rate = 16'h0960;
			3'h4:    baud_rate = 16'h12C0;
			3'h5:    baud_rate = 16'h2580;
			3'h6:    baud_rate = 16'h4B00;
			default: baud_rate = 16'h0000;
		endcase
	endfunction

	// A config word is kept only if its baud, parity and stop bit fields are in range
	function automatic logic cfg_valid(input logic [31:0] w);
		cfg_valid = (w[CFG_BAUD_LSB +: 3] <= BAUD_MAX) &&
			(w[CFG_PAR_LSB +: 2] <= PAR_MAX) &&
			(w[CFG_STOP_LSB +: 2] >= STOP_MIN) &&
			(w[CFG_STOP_LSB +: 2] <= STOP_MAX);
	endfunction

endpackage

// ---- verilog/ram_self_test.sv ----
// Connection board RAM with its write and read-back self test
`timescale 1ns/100ps
module ram_self_test
	import sqa_pkg::*;
(
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// Control
	input  wire logic              start,
	input  wire logic              fault_en,
	input  wire logic [RAM_AW-1:0] fault_addr,
	// Result
	output logic                   busy,
	output logic                   done,
	output logic [15:0]            result
);

	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_CHECK} test_st_t;

	logic [7:0]        mem [RAM_DEPTH];
	test_st_t          st_q, st_d;
	logic [RAM_AW-1:0] addr_q, addr_d, fad_q, fad_d;
	logic              inv_q, inv_d, fen_q, fen_d, done_q, done_d, we;
	logic [15:0]       res_q, res_d;
	logic [7:0]        pat, wdata;
	logic              last;

	// ==========================================================
	// Sequencer: write, check, write inverted, check inverted
	always_comb begin
		st_d   = st_q;
		addr_d = addr_q;
		inv_d  = inv_q;
		fen_d  = fen_q;
		fad_d  = fad_q;
		res_d  = res_q;
		done_d = 1'b0;
		we     = 1'b0;
		last   = (addr_q == RAM_AW'(RAM_DEPTH - 1));
		pat    = RAM_PATTERN ^ addr_q[7:0] ^ {8{inv_q}};
		// Injected fault lets software exercise the failing path
		wdata  = (fen_q && addr_q == fad_q) ? (pat ^ RAM_FLIP) : pat;
		case (st_q)
			ST_IDLE: begin
				if (start) begin
					st_d   = ST_WRITE;
					addr_d = '0;
					inv_d  = 1'b0;
					fen_d  = fault_en;
					fad_d  = fault_addr;
					res_d  = 16'h0000;
				end
			end
			ST_WRITE: begin
				we     = 1'b1;
				addr_d = last ? '0 : addr_q + 1'b1;
				if (last) begin
					st_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (mem[addr_q] != pat) begin
					res_d  = 16'(addr_q); // RULE6
					done_d = 1'b1;
					st_d   = ST_IDLE;
				end else if (last && inv_q) begin
					done_d = 1'b1; // RULE6
					st_d   = ST_IDLE;
				end else if (last) begin
					inv_d  = 1'b1;
					addr_d = '0;
					st_d   = ST_WRITE;
				end else begin
					addr_d = addr_q + 1'b1;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// Memory has no reset: its content is what the test checks
	always_ff @(posedge hclk) begin
		if (we) begin
			mem[addr_q] <= wdata;
		end
	end

	// Sequencer registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q   <= ST_IDLE;
			addr_q <= '0;
			inv_q  <= 1'b0;
			fen_q  <= 1'b0;
			fad_q  <= '0;
			res_q  <= 16'h0000;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			addr_q <= addr_d;
			inv_q  <= inv_d;
			fen_q  <= fen_d;
			fad_q  <= fad_d;
			res_q  <= res_d;
			done_q <= done_d;
		end
	end

	assign busy   = (st_q != ST_IDLE);
	assign done   = done_q;
	assign result = res_q;

	// ==========================================================
	// Checks
	int unsigned run_cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_cnt <= 0;
		end else begin
			run_cnt <= busy ? run_cnt + 1 : 0;
		end
	end

	property p_test_bounded;
		@(posedge hclk) disable iff (!hresetn)
		run_cnt <= RAM_TEST_CYC;
	endproperty
	a_test_bounded: assert property (p_test_bounded) // RULE5
		else $error("RAM test ran too long");

	property p_result_addr;
		@(posedge hclk) disable iff (!hresetn)
		done |-> result == (fen_q ? 16'(fad_q) : 16'h0000);
	endproperty
	a_result_addr: assert property (p_result_addr) // RULE6
		else $error("RAM test result wrong");

endmodule

// ---- verilog/serial_query_and_ack_control.sv ----
// Remote query and acknowledgment control with an AHB-Lite register slave
//
// Overview of operation
// RULE1 - Query parameter: 0 current, 1 RS-232, 2 RS-485
// RULE2 - Settings reply: baud, parity, stop bits, port
// RULE3 - Switch query reports DIP switch banks decimally; the code returns each bank as its raw binary byte
// RULE4 - Parameter 1 returns serial then second bank
// RULE5 - Parameter 2 runs board RAM test
// RULE6 - RAM result zero, else faulty cell address
// RULE7 - Ack select: 0 disables, 1 enables acks
// RULE8 - Queries always reply regardless of ack setting
// RULE9 - Set-up commands acknowledge with 0 or ?
// RULE10 - Power-on acks: bus off, both serial on
// RULE11 - Acks on: 0 on success, ? on error
// RULE12 - Acks off: set-up commands send nothing
// RULE13 - Bus host enables acks before expecting them
// RULE14 - Enabling select command itself answers with 0
// RULE15 - Baud 300 to 19200, parity, one/two stops
// RULE16 - Every serial character has eight data bits
// RULE17 - Missing query parameter means the current port
// RULE18 - One ack flag per interface, own only
`timescale 1ns/100ps
module serial_query_and_ack_control
	import sqa_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Configuration DIP switch pins
	input  wire logic [7:0]  dip_serial,
	input  wire logic [7:0]  dip_second
);

	// ==========================================================
	// Declarations
	logic        wr_q, wr_d;
	logic [7:0]  wa_q, wa_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic        acc;
	logic [7:0]  dser_s1, dser_s2, dsec_s1, dsec_s2;
	logic [1:0][2:0] baud_q, baud_d;
	logic [1:0][1:0] par_q, par_d, stop_q, stop_d;
	logic        fen_q, fen_d;
	logic [RAM_AW-1:0] fad_q, fad_d;
	logic [2:0]  ack_q, ack_d;
	logic        rv_q, rv_d, isack_q, isack_d, pend_q, pend_d;
	logic [3:0][15:0] rq_q, rq_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [7:0]  char_q, char_d;
	logic [15:0] cmd_q, cmd_d;
	logic        cmd_go, clr_rv, ram_start, ram_busy, ram_done;
	logic [15:0] ram_result;
	logic [3:0]  op;
	logic [1:0]  src, tgt;
	logic        hasp, serr, idx;
	logic [7:0]  prm;

	// Command word fields, valid while the data phase stands
	assign op   = hwdata[CMD_OP_LSB +: 4];
	assign src  = hwdata[CMD_SRC_LSB +: 2];
	assign hasp = hwdata[CMD_HASP_BIT];
	assign serr = hwdata[CMD_ERR_BIT];
	assign prm  = hwdata[CMD_PARAM_LSB +: 8];

	// ==========================================================
	// Bus slave: zero wait, read data registered in address phase
	always_comb begin
		acc      = hsel && htrans[1] && hready && (hsize == 3'h2);
		wr_d     = acc && hwrite;
		wa_d     = acc ? haddr[7:0] : wa_q;
		hrdata_d = hrdata_q;
		if (acc && !hwrite) begin
			case (haddr[7:0])
				OFS_CMD:    hrdata_d = {16'h0000, cmd_q};
				OFS_STATUS: hrdata_d = {27'h0, ack_q, rv_q, ram_busy};
				OFS_RESP0:  hrdata_d = {16'h0000, rq_q[0]};
				OFS_RESP1:  hrdata_d = {16'h0000, rq_q[1]};
				OFS_RESP2:  hrdata_d = {16'h0000, rq_q[2]};
				OFS_RESP3:  hrdata_d = {16'h0000, rq_q[3]};
				OFS_RINFO:  hrdata_d = {16'h0000, char_q,
					4'h0, isack_q, cnt_q};
				// Data bits read back fixed, nothing can change them
				OFS_CFG232: hrdata_d = {16'h0000, DATA_BITS, 2'h0,
					stop_q[0], 2'h0, par_q[0], 1'b0, baud_q[0]}; // RULE16
				OFS_CFG485: hrdata_d = {16'h0000, DATA_BITS, 2'h0,
					stop_q[1], 2'h0, par_q[1], 1'b0, baud_q[1]}; // RULE16
				OFS_RAMFLT: hrdata_d = {6'h00, fad_q, 15'h0000, fen_q};
				default:    hrdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q      <= 1'b0;
			wa_q      <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_q      <= wr_d;
			wa_q      <= wa_d;
			hrdata_q  <= hrdata_d;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;

	// Commands are refused while the RAM test still runs
	assign cmd_go = wr_q && (wa_q == OFS_CMD) && !pend_q && (src <= IF_RS485);
	assign clr_rv = wr_q && (wa_q == OFS_STATUS) && hwdata[ST_RV_BIT];

	// ==========================================================
	// DIP switch synchronisers, pins are asynchronous
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dser_s1 <= 8'h00;
			dser_s2 <= 8'h00;
			dsec_s1 <= 8'h00;
			dsec_s2 <= 8'h00;
		end else begin
			dser_s1 <= dip_serial;
			dser_s2 <= dser_s1;
			dsec_s1 <= dip_second;
			dsec_s2 <= dsec_s1;
		end
	end

	// ==========================================================
	// Serial settings and fault injection registers
	always_comb begin
		baud_d = baud_q;
		par_d  = par_q;
		stop_d = stop_q;
		fen_d  = fen_q;
		fad_d  = fad_q;
		// Out of range settings are dropped, keeping the port usable
		if (wr_q && (wa_q == OFS_CFG232) && cfg_valid(hwdata)) begin
			baud_d[0] = hwdata[CFG_BAUD_LSB +: 3]; // RULE15
			par_d[0]  = hwdata[CFG_PAR_LSB +: 2];
			stop_d[0] = hwdata[CFG_STOP_LSB +: 2];
		end
		if (wr_q && (wa_q == OFS_CFG485) && cfg_valid(hwdata)) begin
			baud_d[1] = hwdata[CFG_BAUD_LSB +: 3]; // RULE15
			par_d[1]  = hwdata[CFG_PAR_LSB +: 2];
			stop_d[1] = hwdata[CFG_STOP_LSB +: 2];
		end
		if (wr_q && (wa_q == OFS_RAMFLT)) begin
			fen_d = hwdata[0];
			fad_d = hwdata[FLT_ADDR_LSB +: RAM_AW];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud_q <= {BAUD_RESET, BAUD_RESET};
			par_q  <= {PAR_RESET, PAR_RESET};
			stop_q <= {STOP_RESET, STOP_RESET};
			fen_q  <= 1'b0;
			fad_q  <= '0;
		end else begin
			baud_q <= baud_d;
			par_q  <= par_d;
			stop_q <= stop_d;
			fen_q  <= fen_d;
			fad_q  <= fad_d;
		end
	end

	// ==========================================================
	// Command interpreter and response registers
	always_comb begin
		ack_d     = ack_q;
		rv_d      = rv_q;
		isack_d   = isack_q;
		rq_d      = rq_q;
		cnt_d     = cnt_q;
		char_d    = char_q;
		cmd_d     = cmd_q;
		pend_d    = pend_q;
		ram_start = 1'b0;
		// Absent or zero parameter selects the port that carried it
		tgt = (!hasp || prm == 8'h00) ? src : prm[1:0]; // RULE17 RULE1
		idx = tgt[1];
		// Clear first so a new response in the same cycle wins
		if (clr_rv) begin
			rv_d = 1'b0;
		end
		if (cmd_go) begin
			cmd_d = hwdata[15:0];
			case (op)
				OP_SERIAL_SETTINGS_QUERY: begin
					rv_d = 1'b1; // RULE8
					if ((!hasp || prm <= 8'h02) && tgt != IF_BUS) begin
						isack_d = 1'b0; // RULE2
						cnt_d   = 3'h4;
						rq_d[0] = baud_rate(baud_q[idx]);
						rq_d[1] = {14'h0000, par_q[idx]};
						rq_d[2] = {14'h0000, stop_q[idx]};
						rq_d[3] = {14'h0000, tgt};
					end else begin
						isack_d = 1'b1;
						cnt_d   = 3'h1;
						char_d  = ACK_ERR;
					end
				end
				OP_SWITCH_AND_RAM_QUERY: begin
					if (hasp && prm == 8'h01) begin
						rv_d    = 1'b1; // RULE8
						isack_d = 1'b0; // RULE3 RULE4
						cnt_d   = 3'h2;
						rq_d[0] = {8'h00, dser_s2};
						rq_d[1] = {8'h00, dsec_s2};
					end else if (hasp && prm == 8'h02) begin
						ram_start = 1'b1; // RULE5
						pend_d    = 1'b1;
					end else begin
						rv_d    = 1'b1;
						isack_d = 1'b1;
						cnt_d   = 3'h1;
						char_d  = ACK_ERR;
					end
				end
				OP_ACK_OUTPUT_SELECT: begin
					if (hasp && prm == 8'h01) begin
						ack_d[src] = 1'b1; // RULE7 RULE18
						rv_d       = 1'b1; // RULE14
						isack_d    = 1'b1;
						cnt_d      = 3'h1;
						char_d     = ACK_OK;
					end else if (hasp && prm == 8'h00) begin
						ack_d[src] = 1'b0; // RULE7 RULE18
					end else if (ack_q[src]) begin
						rv_d    = 1'b1;
						isack_d = 1'b1;
						cnt_d   = 3'h1;
						char_d  = ACK_ERR;
					end
				end
				default: begin
					// Other set-up commands: silent while acks are off
					if (ack_q[src]) begin
						rv_d    = 1'b1; // RULE9 RULE11 RULE12
						isack_d = 1'b1;
						cnt_d   = 3'h1;
						char_d  = (op == OP_SETUP_GENERIC && !serr) ?
							ACK_OK : ACK_ERR; // RULE9
					end
				end
			endcase
		end
		if (ram_done && pend_q) begin
			pend_d  = 1'b0;
			rv_d    = 1'b1; // RULE6
			isack_d = 1'b0;
			cnt_d   = 3'h1;
			rq_d[0] = ram_result;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_q   <= ACK_RESET; // RULE10
			rv_q    <= 1'b0;
			isack_q <= 1'b0;
			rq_q    <= '0;
			cnt_q   <= 3'h0;
			char_q  <= 8'h00;
			cmd_q   <= 16'h0000;
			pend_q  <= 1'b0;
		end else begin
			ack_q   <= ack_d;
			rv_q    <= rv_d;
			isack_q <= isack_d;
			rq_q    <= rq_d;
			cnt_q   <= cnt_d;
			char_q  <= char_d;
			cmd_q   <= cmd_d;
			pend_q  <= pend_d;
		end
	end

	// Connection board RAM and its self test
	ram_self_test u_ram (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.start      (ram_start),
		.fault_en   (fen_q),
		.fault_addr (fad_q),
		.busy       (ram_busy),
		.done       (ram_done),
		.result     (ram_result)
	);

	// ==========================================================
	// Checks
	property p_ack_default;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> ack_q == ACK_RESET;
	endproperty
	a_ack_default: assert property (p_ack_default) // RULE10
		else $error("ack enables not at power-on values");

	property p_query_reply;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && (op == OP_SERIAL_SETTINGS_QUERY ||
			(op == OP_SWITCH_AND_RAM_QUERY && hasp && prm == 8'h01))
		|=> rv_q && (cnt_q != 3'h0);
	endproperty
	a_query_reply: assert property (p_query_reply) // RULE8
		else $error("query gave no reply");

	property p_setup_silent;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && op == OP_SETUP_GENERIC && !ack_q[src]
		|=> rv_q == $past(rv_q) && char_q == $past(char_q);
	endproperty
	a_setup_silent: assert property (p_setup_silent) // RULE12
		else $error("set-up reply sent with acks off");

	property p_setup_ack;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && op == OP_SETUP_GENERIC && ack_q[src]
		|=> rv_q && isack_q &&
			char_q == ($past(hwdata[CMD_ERR_BIT]) ? ACK_ERR : ACK_OK);
	endproperty
	a_setup_ack: assert property (p_setup_ack) // RULE11
		else $error("set-up ack wrong");

	property p_select_on;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && op == OP_ACK_OUTPUT_SELECT && hasp && prm == 8'h01
		|=> ack_q[$past(src)] && rv_q && char_q == ACK_OK;
	endproperty
	a_select_on: assert property (p_select_on) // RULE14
		else $error("enabling select not acknowledged");

	property p_select_own;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && op == OP_ACK_OUTPUT_SELECT
		|=> (ack_q & ~(3'h1 << $past(src))) ==
			($past(ack_q) & ~(3'h1 << $past(src)));
	endproperty
	a_select_own: assert property (p_select_own) // RULE18
		else $error("select changed another interface");

	property p_current_port;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && op == OP_SERIAL_SETTINGS_QUERY && !hasp && src != IF_BUS
		|=> cnt_q == 3'h4 && rq_q[3] == {14'h0000, $past(src)} &&
			rq_q[0] == baud_rate(baud_q[$past(src[1])]);
	endproperty
	a_current_port: assert property (p_current_port) // RULE17
		else $error("settings query reported wrong port");

	property p_switch_banks;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && op == OP_SWITCH_AND_RAM_QUERY && hasp && prm == 8'h01
		|=> cnt_q == 3'h2 && rq_q[0][7:0] == $past(dser_s2) &&
			rq_q[1][7:0] == $past(dsec_s2);
	endproperty
	a_switch_banks: assert property (p_switch_banks) // RULE4
		else $error("switch bank order wrong");

	property p_cfg_range;
		@(posedge hclk) disable iff (!hresetn)
		baud_q[0] <= BAUD_MAX && baud_q[1] <= BAUD_MAX &&
			par_q[0] <= PAR_MAX && par_q[1] <= PAR_MAX &&
			stop_q[0] >= STOP_MIN && stop_q[1] >= STOP_MIN &&
			stop_q[0] <= STOP_MAX && stop_q[1] <= STOP_MAX;
	endproperty
	a_cfg_range: assert property (p_cfg_range) // RULE15
		else $error("serial setting out of range");

	property p_ram_reply;
		@(posedge hclk) disable iff (!hresetn)
		ram_done && pend_q |=> rv_q && cnt_q == 3'h1 &&
			rq_q[0] == $past(ram_result) && !pend_q;
	endproperty
	a_ram_reply: assert property (p_ram_reply) // RULE6
		else $error("RAM test result not reported");

endmodule

// ---- dv/sqa_host_model.sv ----
// Host computer model: AHB-Lite master for single word transfers
`timescale 1ns/100ps
module sqa_host_model (
	// Clock and bus answer
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// Master outputs
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	output logic             hang
);
	// ==========================================
	// Idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hang = 1'b0;
	end

	// Wait for hready at an edge, never forever
	task rdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1) begin
			hang = 1'b1;
		end
	endtask

	// One transfer: address phase, then data phase
	task xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rq);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rq = hrdata;
		// Released data shows junk so a stale value never passes
		hwdata <= ~d;
	endtask
endmodule

// ---- dv/serial_query_and_ack_control_tb_top.sv ----
// Self-checking bench for the query and acknowledgment block
`timescale 1ns/100ps
module serial_query_and_ack_control_tb_top;
	import sqa_pkg::*;
	// ==========================================
	// Short opcode names
	localparam logic [3:0] SQ = OP_SERIAL_SETTINGS_QUERY;
	localparam logic [3:0] SW = OP_SWITCH_AND_RAM_QUERY;
	localparam logic [3:0] AS = OP_ACK_OUTPUT_SELECT;
	localparam logic [3:0] SU = OP_SETUP_GENERIC;
	// Pins and bench state
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hresp;
	logic        hang;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [7:0]  dip_serial;
	logic [7:0]  dip_second;
	logic [7:0]  ch;
	int          n_errors;
	int          n_tests;
	int          i;
	int          j;

	serial_query_and_ack_control dut_u (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.dip_serial(dip_serial), .dip_second(dip_second));
	sqa_host_model host_u (.hclk(hclk), .hready(hready),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));

	// 25 MHz clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// ==========================================
	// Reporting
	task final_report();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, got);
		end
	endtask

	// A stuck bus ends the run
	always @(posedge hang) begin
		n_errors++;
		final_report();
	end

	// ==========================================
	// Bus and command helpers
	task rd(input logic [7:0] a, output logic [31:0] rq);
		host_u.xfer(1'b0, a, 32'h0, rq);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		host_u.xfer(1'b1, a, d, dummy);
	endtask

	task cmd(input logic [3:0] op, input logic [1:0] src,
		input logic hp, input logic [7:0] p, input logic err);
		wr(OFS_CMD, {16'h0, p, err, hp, src, op});
	endtask

	// Expect a response or none, then clear it
	task rsp(input logic e, input logic [15:0] ri, input logic [63:0] r);
		rd(OFS_STATUS, q);
		chk("rv", {31'h0, q[ST_RV_BIT]}, {31'h0, e});
		if (e) begin
			// Value replies leave the last ack character in place
			if (ri[3]) begin
				ch = ri[15:8];
			end
			rd(OFS_RINFO, q);
			chk("rinfo", q, {16'h0, ch, ri[7:0]});
			for (j = 0; j < 4; j++) begin
				if (!ri[3] && j < int'(ri[2:0])) begin
					rd(OFS_RESP0 + 8'(4 * j), q);
					chk("resp", q, {16'h0, r[63 - 16 * j -: 16]});
				end
			end
			wr(OFS_STATUS, 32'h2);
		end
	endtask

	task go(input logic [3:0] op, input logic [1:0] src, input logic hp,
		input logic [7:0] p, input logic err, input logic e,
		input logic [15:0] ri, input logic [63:0] r);
		cmd(op, src, hp, p, err);
		rsp(e, ri, r);
	endtask

	task acks(input logic [2:0] e);
		rd(OFS_STATUS, q);
		chk("acks", {29'h0, q[ST_ACK_LSB +: 3]}, {29'h0, e});
	endtask

	// ==========================================
	// Scenarios
	task t_reset();
		rd(OFS_STATUS, q);
		chk("status", q, 32'h18);
		rd(OFS_CFG232, q);
		chk("cfg232", q, 32'h8125);
		rd(8'h40, q);
		chk("unmapped", q, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task t_serial();
		wr(OFS_CFG232, 32'h216);
		wr(OFS_CFG485, 32'h305);
		rd(OFS_CFG485, q);
		chk("cfg485", q, 32'h8125);
		rd(OFS_CFG232, q);
		chk("cfg232", q, 32'h8216);
		go(SQ, IF_RS232, 0, 0, 0, 1, 16'h4, 64'h4B00_0001_0002_0001);
		go(SQ, IF_BUS, 1, 1, 0, 1, 16'h4, 64'h4B00_0001_0002_0001);
		go(SQ, IF_RS232, 1, 2, 0, 1, 16'h4, 64'h2580_0002_0001_0002);
		go(SQ, IF_RS485, 1, 0, 0, 1, 16'h4, 64'h2580_0002_0001_0002);
		go(SQ, IF_BUS, 1, 0, 0, 1, 16'h3F09, 64'h0);
		go(SQ, IF_RS232, 1, 3, 0, 1, 16'h3F09, 64'h0);
	endtask

	task t_switch();
		go(SW, IF_RS232, 1, 1, 0, 1, 16'h2, 64'h0081_0064_0000_0000);
		dip_serial <= 8'h5A;
		dip_second <= 8'hA5;
		repeat (3) @(posedge hclk);
		go(SW, IF_RS485, 1, 1, 0, 1, 16'h2, 64'h005A_00A5_0000_0000);
		go(SW, IF_BUS, 1, 3, 0, 1, 16'h3F09, 64'h0);
	endtask

	// RAM test; a command sent meanwhile must be dropped
	task t_ram(input logic [9:0] fa, input logic fe, input logic [15:0] e);
		wr(OFS_RAMFLT, {6'h0, fa, 15'h0, fe});
		cmd(SW, IF_RS232, 1, 2, 0);
		rd(OFS_STATUS, q);
		chk("busy", {31'h0, q[ST_BUSY_BIT]}, 32'h1);
		cmd(AS, IF_BUS, 1, 1, 0);
		// Refused command leaves the accepted one in readback
		rd(OFS_CMD, q);
		chk("cmd", q, 32'h0252);
		i = 0;
		do begin
			rd(OFS_STATUS, q);
			i++;
		end while (q[ST_BUSY_BIT] !== 1'b0 && i < 3000);
		if (q[ST_BUSY_BIT] !== 1'b0) begin
			n_errors++;
			final_report();
		end
		rsp(1, 16'h1, {e, 48'h0});
		acks(3'h6);
	endtask

	task t_ack();
		go(SU, IF_BUS, 0, 0, 0, 0, 0, 0);
		go(SU, IF_BUS, 0, 0, 1, 0, 0, 0);
		go(AS, IF_BUS, 1, 1, 0, 1, 16'h3009, 0);
		acks(3'h7);
		go(SU, IF_BUS, 0, 0, 0, 1, 16'h3009, 0);
		go(SU, IF_BUS, 0, 0, 1, 1, 16'h3F09, 0);
		go(4'hF, IF_BUS, 0, 0, 0, 1, 16'h3F09, 0);
		go(AS, IF_RS232, 1, 0, 0, 0, 0, 0);
		acks(3'h5);
		go(SU, IF_RS232, 0, 0, 1, 0, 0, 0);
		go(SQ, IF_RS232, 0, 0, 0, 1, 16'h4, 64'h4B00_0001_0002_0001);
		go(AS, IF_RS485, 1, 5, 0, 1, 16'h3F09, 0);
		acks(3'h5);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		hresetn = 1'b0;
		dip_serial = 8'h81;
		dip_second = 8'h64;
		ch = 8'h00;
		n_errors = 0;
		n_tests = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		t_reset();
		t_serial();
		t_switch();
		t_ram(10'h0, 1'b0, 16'h0);
		t_ram(10'h2A5, 1'b1, 16'h2A5);
		t_ack();
		final_report();
	end
endmodule
